// >>> inc/cie_defs.vh
// Constants of the interrupt and exception unit
//--------------------------------------------------------------------
// Function
//--------------------------------------------------------------------
// Function
// - Eight-bit port numbers are zero-extended; 16-bit ports come from port register.
// - Entry pushes status word, then code segment and instruction pointer.
// - Escape trap returns to escape opcode, or to its segment override prefix.
// - Other exceptions return to the instruction after the faulting one.
// - Vector table holds 256 four-byte pointers at type times four.
// - Exceptions and non-maskable use internal vectors; maskable vector from acknowledge only for cascaded external requests.
// - Hardware requests sampled at instruction end; software interrupts go first.
// - Divide quotient overflow raises type 0.
// - Trace flag raises type 1 except after prefix, segment load, wait.
// - Single-step entry clears trace; return restores it and resumes.
// - Non-maskable uses type 2 regardless of enable, no acknowledge, clears enable.
// - Breakpoint instruction is type 3, pointer at byte offset 12.
// - Overflow-trap instruction raises type 4 only while overflow flag set.
// - Bounds check out of limits raises type 5.
// - Undefined opcode raises type 6.
// - Escape opcodes raise type 7; enhanced mode only with escape-trap bit.
// - Unmasked coprocessor error is type 16, caught at next numerics instruction.
// - Maskable requests need enable flag; entry clears it after saving status.
// - Return that re-enables with pending request services it immediately.
// - Three timers share one level, timer 0 over 1 over 2.
// - Default types: timers 8,18,19; DMA 10,11; external 12 to 15.
//--------------------------------------------------------------------
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH
`define CIE_VT_DIVIDE    8'h00
`define CIE_VT_STEP      8'h01
`define CIE_VT_NMI       8'h02
`define CIE_VT_BREAK     8'h03
`define CIE_VT_OVERFLOW  8'h04
`define CIE_VT_BOUNDS    8'h05
`define CIE_VT_UNDEF     8'h06
`define CIE_VT_ESCAPE    8'h07
`define CIE_VT_TIMER0    8'h08
`define CIE_VT_DMA0      8'h0A
`define CIE_VT_DMA1      8'h0B
`define CIE_VT_EXT0      8'h0C
`define CIE_VT_NUMERIC   8'h10
`define CIE_VT_TIMER1    8'h12
`define CIE_VT_TIMER2    8'h13
`define CIE_RSV_PORT_LO  16'h00F8
`define CIE_RSV_PORT_HI  16'h00FF
`define CIE_FLAG_TRACE   8
`define CIE_FLAG_IENABLE 9
`define CIE_FLAG_OVER    11
`define CIE_STATUS_RST   16'hF002
`endif

// >>> src/cie_irq_arbiter.v
// Fixed-priority arbiter for the integrated interrupt sources
`timescale 1ns/1ps
`include "cie_defs.vh"
module cie_irq_arbiter (
   // Requests: timers 0..2, dma 0..1, external 0..3
   input  wire [2:0] i_timer_req,
   input  wire [1:0] i_dma_req,
   input  wire [3:0] i_ext_req,
   // Programmed types for slave mode
   input  wire       i_slave_mode,
   input  wire [7:0] i_slv_timer0_type,
   input  wire [7:0] i_slv_timer1_type,
   input  wire [7:0] i_slv_timer2_type,
   input  wire [7:0] i_slv_dma0_type,
   input  wire [7:0] i_slv_dma1_type,
   // Result
   output reg        o_req,
   output reg  [7:0] o_type
);
   integer k;
   always @* begin
      o_req  = 1'b0;
      o_type = 8'h00;
      // Walk lowest priority first so the highest overrides
      for (k = 3; k >= 0; k = k - 1) begin
         if (i_ext_req[k]) begin
            o_req  = 1'b1;
            o_type = `CIE_VT_EXT0 + k[7:0];
         end
      end
      if (i_dma_req[1]) begin
         o_req  = 1'b1;
         o_type = i_slave_mode ? i_slv_dma1_type : `CIE_VT_DMA1;
      end
      if (i_dma_req[0]) begin
         o_req  = 1'b1;
         o_type = i_slave_mode ? i_slv_dma0_type : `CIE_VT_DMA0;
      end
      if (i_timer_req[2]) begin
         o_req  = 1'b1;
         o_type = i_slave_mode ? i_slv_timer2_type : `CIE_VT_TIMER2;
      end
      if (i_timer_req[1]) begin
         o_req  = 1'b1;
         o_type = i_slave_mode ? i_slv_timer1_type : `CIE_VT_TIMER1;
      end
      if (i_timer_req[0]) begin
         o_req  = 1'b1;
         o_type = i_slave_mode ? i_slv_timer0_type : `CIE_VT_TIMER0;
      end
   end
endmodule // cie_irq_arbiter

// >>> src/cie_exception_unit.v
// Interrupt and exception sequencing unit of the processor core
`timescale 1ns/1ps
`include "cie_defs.vh"
module cie_exception_unit (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_nrst,
   // I/O port addressing
   input  wire        i_io_short,
   input  wire [7:0]  i_io_port8,
   input  wire [15:0] i_port_address_register,
   output reg  [15:0] o_io_addr,
   output reg         o_io_reserved,
   // Instruction-end report from the execution unit
   input  wire        i_instr_end,
   input  wire [15:0] i_cs,
   input  wire [15:0] i_ip_this,
   input  wire [15:0] i_ip_next,
   input  wire [15:0] i_ip_prefix,
   input  wire        i_has_seg_prefix,
   input  wire        i_no_step,
   input  wire        i_divide_overflow,
   input  wire        i_overflow_trap_instr,
   input  wire        i_breakpoint_instr,
   input  wire        i_soft_int,
   input  wire [7:0]  i_soft_type,
   input  wire        i_bounds_fail,
   input  wire        i_undef_opcode,
   input  wire        i_coprocessor_escape_opcode,
   input  wire        i_numeric_instr,
   input  wire        i_interrupt_return,
   input  wire [15:0] i_popped_status,
   input  wire        i_set_ienable,
   input  wire        i_clr_ienable,
   input  wire        i_set_trace,
   input  wire        i_clr_trace,
   // Mode and pin inputs (asynchronous)
   input  wire        i_enhanced_mode,
   input  wire        i_escape_trap_bit,
   input  wire        i_nmi,
   input  wire        i_coproc_error,
   input  wire [3:0]  i_maskable_request_inputs,
   // Integrated controller sources
   input  wire [2:0]  i_timer_req,
   input  wire [1:0]  i_dma_req,
   input  wire        i_slave_mode,
   input  wire [7:0]  i_slv_timer0_type,
   input  wire [7:0]  i_slv_timer1_type,
   input  wire [7:0]  i_slv_timer2_type,
   input  wire [7:0]  i_slv_dma0_type,
   input  wire [7:0]  i_slv_dma1_type,
   // External acknowledge vector
   input  wire        i_ext_cascade,
   input  wire        i_ack_valid,
   input  wire [7:0]  i_ack_type,
   output reg         o_ack_cycle,
   // Stack push and vector fetch
   output reg         o_push_valid,
   output reg  [15:0] o_push_data,
   input  wire        i_push_ready,
   output reg         o_vector_valid,
   output reg  [9:0]  o_vector_addr,
   output reg  [7:0]  o_vector_type,
   output reg         o_busy,
   // Status
   output reg  [15:0] o_status_word
);
   //------------------------------------------------------------------
   // Synchronisers
   //------------------------------------------------------------------
   reg [5:0] sync1_reg;
   reg [5:0] sync2_reg;
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end else begin
         sync1_reg <= {i_nmi, i_coproc_error, i_maskable_request_inputs};
         sync2_reg <= sync1_reg;
      end
   end
   wire [3:0] ext_req   = sync2_reg[3:0];
   wire       cop_err   = sync2_reg[4];
   wire       nmi_level = sync2_reg[5];
   //------------------------------------------------------------------
   // Port address
   //------------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_io_addr     <= 16'h0000;
         o_io_reserved <= 1'b0;
      end else begin
         if (i_io_short) begin
            o_io_addr <= {8'h00, i_io_port8};
         end else begin
            o_io_addr <= i_port_address_register;
         end
         o_io_reserved <= i_io_short ?
            ({8'h00, i_io_port8} >= `CIE_RSV_PORT_LO) :
            (i_port_address_register >= `CIE_RSV_PORT_LO &&
             i_port_address_register <= `CIE_RSV_PORT_HI);
      end
   end
   //------------------------------------------------------------------
   // Hardware request arbitration
   //------------------------------------------------------------------
   wire       arb_req;
   wire [7:0] arb_type;
   // Cascaded external requests take the acknowledge path instead
   wire [3:0] arb_ext = ext_req & {4{~i_ext_cascade}};
   cie_irq_arbiter u_arb (
      .i_timer_req       (i_timer_req),
      .i_dma_req         (i_dma_req),
      .i_ext_req         (arb_ext),
      .i_slave_mode      (i_slave_mode),
      .i_slv_timer0_type (i_slv_timer0_type),
      .i_slv_timer1_type (i_slv_timer1_type),
      .i_slv_timer2_type (i_slv_timer2_type),
      .i_slv_dma0_type   (i_slv_dma0_type),
      .i_slv_dma1_type   (i_slv_dma1_type),
      .o_req             (arb_req),
      .o_type            (arb_type)
   );
   //------------------------------------------------------------------
   // Pending events
   //------------------------------------------------------------------
   reg nmi_prev_reg;
   reg nmi_pend_reg;
   reg cop_pend_reg;
   wire nmi_rise = nmi_level & ~nmi_prev_reg;
   //------------------------------------------------------------------
   // Sequencer
   //------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ACK  = 3'd1;
   localparam [2:0] ST_PSW  = 3'd2;
   localparam [2:0] ST_PCS  = 3'd3;
   localparam [2:0] ST_PIP  = 3'd4;
   localparam [2:0] ST_VEC  = 3'd5;
   reg [2:0]  state_reg;
   reg [15:0] ret_ip_reg;
   reg [15:0] ret_cs_reg;
   reg [15:0] saved_sw_reg;
   reg [7:0]  type_reg;
   wire trace   = o_status_word[`CIE_FLAG_TRACE];
   wire ovf     = o_status_word[`CIE_FLAG_OVER];
   wire esc_trap = i_coprocessor_escape_opcode &
                   (~i_enhanced_mode | i_escape_trap_bit);
   // Status after this instruction, used when an interrupt return re-enables
   wire [15:0] sw_after = i_interrupt_return ? i_popped_status : o_status_word;
   wire        ie_after = sw_after[`CIE_FLAG_IENABLE];
   reg        take;
   reg [7:0]  take_type;
   reg [15:0] take_ip;
   reg        take_ack;
   reg        take_cop;
   always @* begin
      take      = 1'b0;
      take_type = 8'h00;
      take_ip   = i_ip_next;
      take_ack  = 1'b0;
      take_cop  = 1'b0;
      if (i_divide_overflow) begin
         take      = 1'b1;
         take_type = `CIE_VT_DIVIDE;
      end else if (i_undef_opcode) begin
         take      = 1'b1;
         take_type = `CIE_VT_UNDEF;
      end else if (esc_trap) begin
         take      = 1'b1;
         take_type = `CIE_VT_ESCAPE;
         take_ip   = i_has_seg_prefix ? i_ip_prefix : i_ip_this;
      end else if (i_numeric_instr && cop_pend_reg) begin
         take      = 1'b1;
         take_type = `CIE_VT_NUMERIC;
         take_cop  = 1'b1;
      end else if (i_bounds_fail) begin
         take      = 1'b1;
         take_type = `CIE_VT_BOUNDS;
      end else if (i_overflow_trap_instr && ovf) begin
         take      = 1'b1;
         take_type = `CIE_VT_OVERFLOW;
      end else if (i_breakpoint_instr) begin
         take      = 1'b1;
         take_type = `CIE_VT_BREAK;
      end else if (i_soft_int) begin
         take      = 1'b1;
         take_type = i_soft_type;
      end else if (nmi_pend_reg) begin
         take      = 1'b1;
         take_type = `CIE_VT_NMI;
      end else if (arb_req && ie_after) begin
         take      = 1'b1;
         take_type = arb_type;
      end else if (ext_req != 4'h0 && ie_after && i_ext_cascade) begin
         take      = 1'b1;
         take_ack  = 1'b1;
      end else if (trace && !i_no_step && !i_interrupt_return) begin
         take      = 1'b1;
         take_type = `CIE_VT_STEP;
      end else if (i_interrupt_return && i_popped_status[`CIE_FLAG_TRACE] && !i_no_step) begin
         take      = 1'b1;
         take_type = `CIE_VT_STEP;
      end
   end
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg      <= ST_IDLE;
         o_status_word  <= `CIE_STATUS_RST;
         ret_ip_reg     <= 16'h0000;
         ret_cs_reg     <= 16'h0000;
         saved_sw_reg   <= 16'h0000;
         type_reg       <= 8'h00;
         nmi_prev_reg   <= 1'b0;
         nmi_pend_reg   <= 1'b0;
         cop_pend_reg   <= 1'b0;
         o_ack_cycle    <= 1'b0;
         o_push_valid   <= 1'b0;
         o_push_data    <= 16'h0000;
         o_vector_valid <= 1'b0;
         o_vector_addr  <= 10'h000;
         o_vector_type  <= 8'h00;
         o_busy         <= 1'b0;
      end else begin
         nmi_prev_reg   <= nmi_level;
         o_vector_valid <= 1'b0;
         if (cop_err) begin
            cop_pend_reg <= 1'b1;
         end
         if (nmi_rise) begin
            nmi_pend_reg <= 1'b1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (i_instr_end) begin
                  if (i_interrupt_return) begin
                     o_status_word <= i_popped_status;
                  end else begin
                     if (i_set_ienable) o_status_word[`CIE_FLAG_IENABLE] <= 1'b1;
                     if (i_clr_ienable) o_status_word[`CIE_FLAG_IENABLE] <= 1'b0;
                     if (i_set_trace)   o_status_word[`CIE_FLAG_TRACE] <= 1'b1;
                     if (i_clr_trace)   o_status_word[`CIE_FLAG_TRACE] <= 1'b0;
                  end
                  if (take) begin
                     saved_sw_reg <= sw_after;
                     ret_cs_reg   <= i_cs;
                     ret_ip_reg   <= take_ip;
                     type_reg     <= take_type;
                     o_busy       <= 1'b1;
                     if (take_ack) begin
                        o_ack_cycle <= 1'b1;
                        state_reg   <= ST_ACK;
                     end else begin
                        state_reg <= ST_PSW;
                     end
                     if (take_type == `CIE_VT_NMI && !take_ack && !i_soft_int) begin
                        nmi_pend_reg <= nmi_rise;
                     end
                     if (take_cop && !cop_err) begin
                        cop_pend_reg <= 1'b0;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (i_ack_valid) begin
                  o_ack_cycle <= 1'b0;
                  type_reg    <= i_ack_type;
                  state_reg   <= ST_PSW;
               end
            end
            ST_PSW: begin
               o_push_valid <= 1'b1;
               o_push_data  <= saved_sw_reg;
               // Entry clears enable and trace after saving the old word
               o_status_word[`CIE_FLAG_IENABLE] <= 1'b0;
               o_status_word[`CIE_FLAG_TRACE]   <= 1'b0;
               if (o_push_valid && i_push_ready) begin
                  o_push_data <= ret_cs_reg;
                  state_reg   <= ST_PCS;
               end
            end
            ST_PCS: begin
               if (i_push_ready) begin
                  o_push_data <= ret_ip_reg;
                  state_reg   <= ST_PIP;
               end
            end
            ST_PIP: begin
               if (i_push_ready) begin
                  o_push_valid <= 1'b0;
                  state_reg    <= ST_VEC;
               end
            end
            ST_VEC: begin
               o_vector_valid <= 1'b1;
               o_vector_type  <= type_reg;
               o_vector_addr  <= {type_reg, 2'b00};
               o_busy         <= 1'b0;
               state_reg      <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // cie_exception_unit

// >>> test/cie_exception_unit_properties.sv
// Port checker of the interrupt and exception unit
`timescale 1ns/1ps
module cie_exception_unit_properties (
   // Clock and reset
   input wire        i_core_clk,
   input wire        i_nrst,
   // Port addressing
   input wire        i_io_short,
   input wire [7:0]  i_io_port8,
   input wire [15:0] i_port_address_register,
   input wire [15:0] o_io_addr,
   input wire        o_io_reserved,
   // Entry sequence
   input wire        i_push_ready,
   input wire        o_push_valid,
   input wire [15:0] o_push_data,
   input wire        o_vector_valid,
   input wire [9:0]  o_vector_addr,
   input wire [7:0]  o_vector_type,
   input wire        o_busy,
   input wire        o_ack_cycle,
   input wire [15:0] o_status_word
);
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   a_io_short: assert property (i_io_short |=> o_io_addr == {8'h00, $past(i_io_port8)})
      else $error("short port not zero-extended");
   a_io_wide: assert property (!i_io_short |=> o_io_addr == $past(i_port_address_register))
      else $error("wide port address wrong");
   a_io_reserved: assert property (o_io_reserved == (o_io_addr >= 16'h00F8 && o_io_addr <= 16'h00FF))
      else $error("reserved port flag wrong");
   a_vector_addr: assert property (o_vector_valid |-> o_vector_addr == {o_vector_type, 2'b00})
      else $error("table address is not type times four");
   a_vector_pulse: assert property (o_vector_valid |=> !o_vector_valid && !o_busy)
      else $error("vector pulse longer than one cycle");
   a_push_hold: assert property (o_push_valid && !i_push_ready |=> o_push_valid && $stable(o_push_data))
      else $error("stack word dropped before accepted");
   a_entry_bound: assert property ($rose(o_busy) |-> ##[1:300] o_vector_valid)
      else $error("entry did not reach the vector");
   a_entry_masks: assert property (o_vector_valid |-> !o_status_word[9] && !o_status_word[8])
      else $error("enable or trace flag still set at vector");
   a_ack_first: assert property (o_ack_cycle |-> o_busy && !o_push_valid)
      else $error("acknowledge outside entry");
endmodule // cie_exception_unit_properties

bind cie_exception_unit cie_exception_unit_properties u_props (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_io_short(i_io_short), .i_io_port8(i_io_port8),
   .i_port_address_register(i_port_address_register), .o_io_addr(o_io_addr),
   .o_io_reserved(o_io_reserved), .i_push_ready(i_push_ready), .o_push_valid(o_push_valid),
   .o_push_data(o_push_data), .o_vector_valid(o_vector_valid), .o_vector_addr(o_vector_addr),
   .o_vector_type(o_vector_type), .o_busy(o_busy), .o_ack_cycle(o_ack_cycle),
   .o_status_word(o_status_word));

// >>> test/cie_far_model.sv
// Far side model: stack acceptor and acknowledge responder
`timescale 1ns/1ps
module cie_far_model (
   // Clock and reset
   input  wire       i_core_clk,
   input  wire       i_nrst,
   // Unit side
   input  wire       i_ack_cycle,
   input  wire [7:0] i_vec,
   output reg        o_push_ready,
   output reg        o_ack_valid,
   output reg  [7:0] o_ack_type
);
   // ------------------------------------------------
   // Random stalls, one-cycle vector answer
   // ------------------------------------------------
   integer    seed;
   reg [31:0] r;
   initial seed = 32'h2aff;
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_push_ready <= 1'b0;
         o_ack_valid  <= 1'b0;
         o_ack_type   <= 8'h00;
      end else begin
         r = $random(seed);
         o_push_ready <= r[0] | r[1];
         o_ack_valid  <= i_ack_cycle & ~o_ack_valid & r[2];
         o_ack_type   <= (i_ack_cycle & ~o_ack_valid & r[2]) ? i_vec : r[10:3];
      end
   end
endmodule // cie_far_model

// >>> test/tb_top.sv
// Self-checking bench of the interrupt and exception unit
`timescale 1ns/1ps
module tb_top;
   reg         clk, nrst, iend, ios, hp, en, etb, nmi, cerr, casc, slv;
   reg  [7:0]  p8, av;
   reg  [8:0]  rq;
   reg  [11:0] cz;
   reg  [39:0] slt;
   reg  [15:0] par, cs, ipt, ipn, ipp, pv, pn, sw;
   reg  [31:0] x;
   wire        io_rsv, ack_cyc, pval, vval, busy, rdy, ackv;
   wire [15:0] io_addr, pdat, stw;
   wire [9:0]  vadr;
   wire [7:0]  vtyp, akt;
   integer     seed, num_errors, comparisons, cyc, k;

   cie_exception_unit dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_io_short(ios), .i_io_port8(p8),
      .i_port_address_register(par), .o_io_addr(io_addr), .o_io_reserved(io_rsv),
      .i_instr_end(iend), .i_cs(cs), .i_ip_this(ipt), .i_ip_next(ipn), .i_ip_prefix(ipp),
      .i_has_seg_prefix(hp), .i_no_step(cz[8]), .i_divide_overflow(cz[0]),
      .i_overflow_trap_instr(cz[4]), .i_breakpoint_instr(cz[5]), .i_soft_int(cz[6]),
      .i_soft_type(av), .i_bounds_fail(cz[3]), .i_undef_opcode(cz[1]),
      .i_coprocessor_escape_opcode(cz[2]), .i_numeric_instr(cz[7]),
      .i_interrupt_return(cz[9]), .i_popped_status(pv), .i_set_ienable(cz[10]),
      .i_clr_ienable(cz[11]), .i_set_trace(1'b0), .i_clr_trace(1'b0),
      .i_enhanced_mode(en), .i_escape_trap_bit(etb), .i_nmi(nmi), .i_coproc_error(cerr),
      .i_maskable_request_inputs(rq[8:5]), .i_timer_req(rq[2:0]), .i_dma_req(rq[4:3]),
      .i_slave_mode(slv), .i_slv_timer0_type(slt[7:0]), .i_slv_timer1_type(slt[15:8]),
      .i_slv_timer2_type(slt[23:16]), .i_slv_dma0_type(slt[31:24]),
      .i_slv_dma1_type(slt[39:32]), .i_ext_cascade(casc), .i_ack_valid(ackv),
      .i_ack_type(akt), .o_ack_cycle(ack_cyc), .o_push_valid(pval), .o_push_data(pdat),
      .i_push_ready(rdy), .o_vector_valid(vval), .o_vector_addr(vadr),
      .o_vector_type(vtyp), .o_busy(busy), .o_status_word(stw));

   cie_far_model far (.i_core_clk(clk), .i_nrst(nrst), .i_ack_cycle(ack_cyc), .i_vec(av),
      .o_push_ready(rdy), .o_ack_valid(ackv), .o_ack_type(akt));

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         num_errors = num_errors + 1;
         print_verdict;
      end
   end
   task print_verdict;
      begin
         if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [15:0] s, input [15:0] e);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
         end
      end
   endtask
   function [7:0] ty(input integer n);
      ty = n == 0 ? 8'h08 : n < 3 ? 8'h11 + n : 8'h07 + n;
   endfunction
   task io(input s, input [7:0] p, input [15:0] r);
      reg [15:0] e;
      begin
         @(posedge clk);
         ios <= s;
         p8 <= p;
         par <= r;
         e = s ? {8'h00, p} : r;
         @(posedge clk);
         @(negedge clk);
         chk(io_addr, e);
         chk(io_rsv, e >= 16'h00F8 && e <= 16'h00FF);
      end
   endtask
   // One instruction end, then the expected entry or none
   task fire(input [11:0] c, input [7:0] t, input tk, input ak);
      reg [31:0] y;
      reg [15:0] e2;
      integer    w, n;
      reg        a;
      begin
         x = $random(seed);
         y = $random(seed);
         @(posedge clk);
         {cs, ipt} <= x;
         {ipp, ipn} <= y;
         hp <= y[16];
         pv <= pn;
         iend <= 1'b1;
         cz <= c;
         if (c[9]) sw = pn;
         if (c[10]) sw[9] = 1'b1;
         if (c[11]) sw[9] = 1'b0;
         e2 = !c[2] ? y[15:0] : y[16] ? y[31:16] : x[15:0];
         @(posedge clk);
         iend <= 1'b0;
         cz <= 12'h000;
         a = 1'b0;
         w = 0;
         n = 0;
         while (tk && vval !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
            if (ack_cyc === 1'b1) a = 1'b1;
            if (pval === 1'b1 && rdy === 1'b1) begin
               chk(pdat, w == 0 ? sw : w == 1 ? x[31:16] : e2);
               w = w + 1;
            end
         end
         if (tk) begin
            chk(w[15:0], 16'h0003);
            chk(vtyp, t);
            chk(vadr, {t, 2'b00});
            chk(a, ak);
            sw[9:8] = 2'b00;
         end
         repeat (3) @(negedge clk);
         chk(busy, 1'b0);
         chk(stw, sw);
      end
   endtask
   task mreq(input [8:0] m, input [11:0] c, input [7:0] t, input ak);
      begin
         @(posedge clk);
         rq <= m;
         repeat (3) @(posedge clk);
         fire(c, t, 1'b1, ak);
         @(posedge clk);
         rq <= 9'h000;
      end
   endtask

   // ------------------------------------------------
   // Sequence
   // ------------------------------------------------
   initial begin
      {clk, nrst, iend, ios, hp, en, etb, nmi, cerr, casc, slv} = 11'h000;
      {p8, av, rq, cz, par, cs, ipt, ipn, ipp, pv} = 133'h0;
      seed = 32'h2aff;
      x = $random(seed);
      slt = {x[7:0], x};
      sw = 16'hF002;
      pn = 16'hF002;
      num_errors = 0;
      comparisons = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      io(1'b1, 8'hF8, 16'h1234);
      io(1'b0, 8'h00, 16'h00FF);
      io(1'b0, 8'hFF, 16'h01F8);
      repeat (20) begin
         x = $random(seed);
         io(x[0], x[8:1], x[31:16]);
      end
      fire(12'h010, 8'h00, 1'b0, 1'b0);
      fire(12'h001, 8'h00, 1'b1, 1'b0);
      fire(12'h002, 8'h06, 1'b1, 1'b0);
      fire(12'h004, 8'h07, 1'b1, 1'b0);
      fire(12'h008, 8'h05, 1'b1, 1'b0);
      fire(12'h020, 8'h03, 1'b1, 1'b0);
      fire(12'h021, 8'h00, 1'b1, 1'b0);
      pn = 16'hF802;
      fire(12'h300, 8'h00, 1'b0, 1'b0);
      fire(12'h010, 8'h04, 1'b1, 1'b0);
      @(posedge clk) en <= 1'b1;
      fire(12'h004, 8'h00, 1'b0, 1'b0);
      @(posedge clk) etb <= 1'b1;
      fire(12'h004, 8'h07, 1'b1, 1'b0);
      @(posedge clk) cerr <= 1'b1;
      repeat (4) @(posedge clk);
      cerr <= 1'b0;
      fire(12'h080, 8'h10, 1'b1, 1'b0);
      @(posedge clk) nmi <= 1'b1;
      repeat (4) @(posedge clk);
      fire(12'h000, 8'h02, 1'b1, 1'b0);
      @(posedge clk) nmi <= 1'b0;
      pn = 16'hF102;
      fire(12'h300, 8'h00, 1'b0, 1'b0);
      fire(12'h100, 8'h00, 1'b0, 1'b0);
      fire(12'h000, 8'h01, 1'b1, 1'b0);
      @(posedge clk) rq <= 9'h004;
      repeat (3) @(posedge clk);
      fire(12'h000, 8'h00, 1'b0, 1'b0);
      pn = 16'hF202;
      fire(12'h200, 8'h13, 1'b1, 1'b0);
      for (k = 0; k < 9; k = k + 1) mreq(9'h001 << k, 12'h200, ty(k), 1'b0);
      mreq(9'h007, 12'h200, 8'h08, 1'b0);
      mreq(9'h006, 12'h200, 8'h12, 1'b0);
      @(posedge clk) slv <= 1'b1;
      mreq(9'h001, 12'h200, slt[7:0], 1'b0);
      mreq(9'h010, 12'h200, slt[39:32], 1'b0);
      x = $random(seed);
      @(posedge clk) av <= x[7:0];
      casc <= 1'b1;
      mreq(9'h020, 12'h200, x[7:0], 1'b1);
      fire(12'h400, 8'h00, 1'b0, 1'b0);
      fire(12'h800, 8'h00, 1'b0, 1'b0);
      fire(12'h400, 8'h00, 1'b0, 1'b0);
      mreq(9'h001, 12'h040, av, 1'b0);
      print_verdict;
   end
endmodule // tb_top
